// ===== include/drmp_pkg.sv
// Constants and types shared by the descriptor ring message port
package drmp_pkg;
  // Bus and ring widths
  localparam int unsigned AW         = 32;
  localparam int unsigned DW         = 16;
  localparam int unsigned IW         = 8;
  // Response FIFO shape: last flag plus one word
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned FIFO_W     = 17;
  // Two interrupt identification words lead the area
  localparam logic [31:0] HDR_AREA    = 32'h0000_0004;
  // One descriptor is two words, four bytes
  localparam logic [31:0] DESC_BYTES  = 32'h0000_0004;
  localparam logic [31:0] DESC_HI_OFS = 32'h0000_0002;
  // Envelope fields below text+0
  localparam logic [31:0] LEN_OFS     = 32'h0000_0004;
  localparam logic [31:0] HDR_OFS     = 32'h0000_0002;
  localparam logic [15:0] WORD_BYTES  = 16'h0002;
  // Descriptor high word layout
  localparam int unsigned OWN_BIT    = 15;
  localparam int unsigned FLAG_BIT   = 14;
  localparam int unsigned EHI_W      = 14;
  localparam logic        OWN_HOST   = 1'b0;
  localparam logic        OWN_CTRL   = 1'b1;
  // Envelope header word layout
  localparam int unsigned TYPE_LSB   = 4;
  localparam int unsigned CRED_W     = 4;
  // Reset values
  localparam logic [15:0] CREDIT_RST = 16'h0000;
  localparam logic [7:0]  IDX_RST    = 8'h00;
  // Response message types
  typedef enum logic [3:0] {
    maintenance_packet = 4'h0,
    credit_notice      = 4'h1,
    datagram_packet    = 4'h2,
    sequential_packet  = 4'h3
  } drmp_msg_t;
  // Port sequencer states
  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_DHI = 4'h1, S_DLO = 4'h2, S_PREV = 4'h3,
    S_LEN  = 4'h4, S_HDR = 4'h5, S_TXT = 4'h6, S_LENW = 4'h7,
    S_DWR  = 4'h8, S_DROP = 4'h9
  } drmp_state_t;
endpackage : drmp_pkg

// ===== hdl/drmp_port.sv
// Descriptor ring message port with its response FIFO
`timescale 1ns/1ps

// Response word FIFO, registered ready on the filling side
module drmp_fifo #(
  parameter int unsigned W     = 17,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Filling side
  input  wire logic [W-1:0] inData,
  input  wire logic         inValid,
  output logic              inReady,
  // Draining side
  output logic [W-1:0]      outData,
  output logic              outValid,
  input  wire logic         outReady
);
  localparam int unsigned PW = $clog2(DEPTH);
  logic [W-1:0]  mem [DEPTH];        // Storage words
  logic [PW-1:0] wrPtr_reg, wrPtr_next;
  logic [PW-1:0] rdPtr_reg, rdPtr_next;
  logic [PW:0]   count_reg, count_next;
  logic          ready_reg, ready_next;
  logic          push, pop;

  // Pointer and fill level update
  always_comb begin
    push       = inValid && ready_reg;
    pop        = outReady && (count_reg != '0);
    wrPtr_next = push ? wrPtr_reg + 1'b1 : wrPtr_reg;
    rdPtr_next = pop ? rdPtr_reg + 1'b1 : rdPtr_reg;
    count_next = count_reg + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    ready_next = (count_next != (PW+1)'(DEPTH));
  end

  // State registers and storage write
  always_ff @(posedge clk) begin
    if (rst) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      wrPtr_reg <= wrPtr_next;
      rdPtr_reg <= rdPtr_next;
      count_reg <= count_next;
      ready_reg <= ready_next;
    end
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  assign inReady  = ready_reg;
  assign outValid = (count_reg != '0);
  assign outData  = mem[rdPtr_reg];
endmodule : drmp_fifo

module drmp_port (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Setup from port initialization
  input  wire logic        runEn,
  input  wire logic [31:0] commBase,
  input  wire logic [7:0]  cmdRingLen,
  input  wire logic [7:0]  rspRingLen,
  input  wire logic        xitionIntEn,
  input  wire logic        pollReq,
  // Host memory master
  output logic             memReq,
  output logic             memWe,
  output logic [31:0]      memAddr,
  output logic [15:0]      memWdata,
  input  wire logic [15:0] memRdata,
  input  wire logic        memAck,
  // Response words from the controller
  input  wire logic [15:0] rspData,
  input  wire logic        rspLast,
  input  wire logic        rspValid,
  output logic             rspReady,
  // Command words to the controller
  output logic [15:0]      cmdData,
  output logic             cmdLast,
  output logic             cmdValid,
  input  wire logic        cmdReady,
  // Host interrupt and credit total
  output logic             hostIrq,
  output logic             irqRsp,
  output logic [15:0]      creditTotal
);
  drmp_pkg::drmp_state_t state_reg, state_next;   // Sequencer
  logic        memReq_reg, memReq_next;           // Bus request
  logic        memWe_reg, memWe_next;             // Write access
  logic [31:0] memAddr_reg, memAddr_next;         // Byte address
  logic [15:0] memWdata_reg, memWdata_next;       // Write word
  logic        isRsp_reg, isRsp_next;             // Ring in use
  logic [7:0]  cmdIdx_reg, cmdIdx_next;           // Command slot
  logic [7:0]  rspIdx_reg, rspIdx_next;           // Response slot
  logic        cmdPend_reg, cmdPend_next;         // Poll owed
  logic [15:0] descHi_reg, descHi_next;           // Descriptor hi
  logic [31:0] envAddr_reg, envAddr_next;         // Text+0 address
  logic        prevOwn_reg, prevOwn_next;         // Prior slot owner
  logic [15:0] bufLen_reg, bufLen_next;           // Length field
  logic [15:0] count_reg, count_next;             // Bytes moved
  logic [15:0] hdr_reg, hdr_next;                 // Id, type, credits
  logic        haveHdr_reg, haveHdr_next;         // Message open
  logic        msgDone_reg, msgDone_next;         // Last word sent
  logic [15:0] cmdData_reg, cmdData_next;         // Command word
  logic        cmdLast_reg, cmdLast_next;
  logic        cmdValid_reg, cmdValid_next;
  logic        irq_reg, irq_next;                 // Interrupt pulse
  logic        irqRsp_reg, irqRsp_next;
  logic [15:0] credit_reg, credit_next;           // Credit sum
  // Launch request and address arithmetic
  logic        go, lWe, ack, fifoPop, fifoValid, fifoLast;
  logic [31:0] lAddr, rspBase, cmdBase, ringBase, descAddr, prevAddr;
  logic [15:0] lData, fifoWord;
  logic [7:0]  curIdx, curLen, prevIdx, nextIdx;
  logic [16:0] nextCount;

  // Response word buffer
  drmp_fifo #(.W(drmp_pkg::FIFO_W), .DEPTH(drmp_pkg::FIFO_DEPTH)) i_drmp_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   ({rspLast, rspData}),
    .inValid  (rspValid),
    .inReady  (rspReady),
    .outData  ({fifoLast, fifoWord}),
    .outValid (fifoValid),
    .outReady (fifoPop)
  );

  // Area layout and slot addresses
  always_comb begin
    rspBase  = commBase + drmp_pkg::HDR_AREA;
    cmdBase  = rspBase + {22'h000000, rspRingLen, 2'b00};
    ringBase = isRsp_reg ? rspBase : cmdBase;
    curIdx   = isRsp_reg ? rspIdx_reg : cmdIdx_reg;
    curLen   = isRsp_reg ? rspRingLen : cmdRingLen;
    prevIdx  = (curIdx == 8'h00) ? curLen - 8'h01 : curIdx - 8'h01;
    nextIdx  = (curIdx + 8'h01 >= curLen) ? 8'h00 : curIdx + 8'h01;
    descAddr = ringBase + {22'h000000, curIdx, 2'b00};
    prevAddr = ringBase + {22'h000000, prevIdx, 2'b00};
    nextCount = {1'b0, count_reg} + {1'b0, drmp_pkg::WORD_BYTES};
  end

  // Sequencer, bus launch and stream control
  always_comb begin
    state_next = state_reg;      memReq_next = memReq_reg;
    memWe_next = memWe_reg;      memAddr_next = memAddr_reg;
    memWdata_next = memWdata_reg; isRsp_next = isRsp_reg;
    cmdIdx_next = cmdIdx_reg;    rspIdx_next = rspIdx_reg;
    cmdPend_next = cmdPend_reg;  descHi_next = descHi_reg;
    envAddr_next = envAddr_reg;  prevOwn_next = prevOwn_reg;
    bufLen_next = bufLen_reg;    count_next = count_reg;
    hdr_next = hdr_reg;          haveHdr_next = haveHdr_reg;
    msgDone_next = msgDone_reg;  cmdData_next = cmdData_reg;
    cmdLast_next = cmdLast_reg;  irqRsp_next = irqRsp_reg;
    credit_next = credit_reg;    irq_next = 1'b0;
    go = 1'b0;  lWe = 1'b0;  lAddr = descAddr;  lData = 16'h0000;
    fifoPop = 1'b0;
    ack = memReq_reg && memAck;
    // Stream hand-off clears the command slot
    cmdValid_next = cmdValid_reg && !cmdReady;
    if (pollReq) begin
      cmdPend_next = 1'b1;
    end
    case (state_reg)
      drmp_pkg::S_IDLE: begin
        if (runEn && cmdPend_reg) begin
          isRsp_next = 1'b0;
          state_next = drmp_pkg::S_DHI;
        end else if (runEn && haveHdr_reg) begin
          isRsp_next = 1'b1;
          state_next = drmp_pkg::S_DHI;
        end else if (runEn && fifoValid) begin
          // Open a response: take its header word
          fifoPop = 1'b1;
          hdr_next = fifoWord;
          msgDone_next = fifoLast;
          credit_next = credit_reg + {12'h000, fifoWord[3:0]};
          if (fifoWord[7:4] == drmp_pkg::datagram_packet ||
              fifoWord[7:4] == drmp_pkg::sequential_packet ||
              fifoWord[7:4] == drmp_pkg::maintenance_packet) begin
            haveHdr_next = 1'b1;
          end else if (!fifoLast) begin
            state_next = drmp_pkg::S_DROP;
          end
        end
      end
      drmp_pkg::S_DHI: begin
        go = 1'b1;
        lAddr = descAddr + drmp_pkg::DESC_HI_OFS;
        if (ack) begin
          if (memRdata[drmp_pkg::OWN_BIT] != drmp_pkg::OWN_CTRL) begin
            // Host still owns the slot; leave it alone
            // A poll request in this cycle wins over the clear
            if (!isRsp_reg && !pollReq) begin
              cmdPend_next = 1'b0;
            end
            state_next = drmp_pkg::S_IDLE;
          end else begin
            descHi_next = memRdata;
            state_next = drmp_pkg::S_DLO;
          end
        end
      end
      drmp_pkg::S_DLO: begin
        go = 1'b1;
        if (ack) begin
          envAddr_next = {2'b00, descHi_reg[drmp_pkg::EHI_W-1:0],
                          memRdata[15:1], 1'b0};
          state_next = drmp_pkg::S_PREV;
        end
      end
      drmp_pkg::S_PREV: begin
        // Prior slot owner tells full or empty ring
        go = 1'b1;
        lAddr = prevAddr + drmp_pkg::DESC_HI_OFS;
        if (ack) begin
          prevOwn_next = memRdata[drmp_pkg::OWN_BIT];
          state_next = drmp_pkg::S_LEN;
        end
      end
      drmp_pkg::S_LEN: begin
        go = 1'b1;
        lAddr = envAddr_reg - drmp_pkg::LEN_OFS;
        if (ack) begin
          bufLen_next = memRdata;
          count_next = 16'h0000;
          state_next = drmp_pkg::S_HDR;
        end
      end
      drmp_pkg::S_HDR: begin
        lAddr = envAddr_reg - drmp_pkg::HDR_OFS;
        if (isRsp_reg) begin
          go = 1'b1;
          lWe = 1'b1;
          lData = hdr_reg;
          if (ack) begin
            state_next = msgDone_reg ? drmp_pkg::S_LENW : drmp_pkg::S_TXT;
          end
        end else begin
          go = !cmdValid_reg;
          if (ack) begin
            cmdData_next = memRdata;
            cmdLast_next = (bufLen_reg == 16'h0000);
            cmdValid_next = 1'b1;
            state_next = (bufLen_reg == 16'h0000) ? drmp_pkg::S_DWR
                                                  : drmp_pkg::S_TXT;
          end
        end
      end
      drmp_pkg::S_TXT: begin
        lAddr = envAddr_reg + {16'h0000, count_reg};
        if (!isRsp_reg) begin
          go = !cmdValid_reg;
          if (ack) begin
            cmdData_next = memRdata;
            cmdLast_next = (nextCount >= {1'b0, bufLen_reg});
            cmdValid_next = 1'b1;
            count_next = nextCount[15:0];
            if (nextCount >= {1'b0, bufLen_reg}) begin
              state_next = drmp_pkg::S_DWR;
            end
          end
        end else if (!memReq_reg && nextCount > {1'b0, bufLen_reg}) begin
          state_next = drmp_pkg::S_LENW;
        end else begin
          go = fifoValid;
          lWe = 1'b1;
          lData = fifoWord;
          if (ack) begin
            fifoPop = 1'b1;
            count_next = nextCount[15:0];
            if (fifoLast) begin
              msgDone_next = 1'b1;
              state_next = drmp_pkg::S_LENW;
            end
          end
        end
      end
      drmp_pkg::S_LENW: begin
        go = 1'b1;
        lWe = 1'b1;
        lAddr = envAddr_reg - drmp_pkg::LEN_OFS;
        lData = count_reg;
        if (ack) begin
          state_next = drmp_pkg::S_DWR;
        end
      end
      drmp_pkg::S_DWR: begin
        // Hand the slot back with the flag set
        go = 1'b1;
        lWe = 1'b1;
        lAddr = descAddr + drmp_pkg::DESC_HI_OFS;
        lData = {drmp_pkg::OWN_HOST, 1'b1,
                 descHi_reg[drmp_pkg::EHI_W-1:0]};
        if (ack) begin
          irq_next = descHi_reg[drmp_pkg::FLAG_BIT] && prevOwn_reg &&
                     xitionIntEn;
          irqRsp_next = isRsp_reg;
          if (isRsp_reg) begin
            rspIdx_next = nextIdx;
            haveHdr_next = !msgDone_reg;
            msgDone_next = 1'b0;
          end else begin
            cmdIdx_next = nextIdx;
          end
          state_next = drmp_pkg::S_IDLE;
        end
      end
      drmp_pkg::S_DROP: begin
        // Discard the words of a dropped message
        fifoPop = fifoValid;
        if (fifoValid && fifoLast) begin
          state_next = drmp_pkg::S_IDLE;
        end
      end
      default: state_next = drmp_pkg::S_IDLE;
    endcase
    // One access at a time, held until acknowledged
    if (ack) begin
      memReq_next = 1'b0;
    end else if (!memReq_reg && go) begin
      memReq_next = 1'b1;
      memWe_next = lWe;
      memAddr_next = lAddr;
      memWdata_next = lData;
    end
  end

  // Register update
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= drmp_pkg::S_IDLE;  memReq_reg <= 1'b0;
      memWe_reg <= 1'b0;   memAddr_reg <= 32'h0000_0000;
      memWdata_reg <= 16'h0000;  isRsp_reg <= 1'b0;
      cmdIdx_reg <= drmp_pkg::IDX_RST;  rspIdx_reg <= drmp_pkg::IDX_RST;
      cmdPend_reg <= 1'b0;  descHi_reg <= 16'h0000;
      envAddr_reg <= 32'h0000_0000;  prevOwn_reg <= 1'b0;
      bufLen_reg <= 16'h0000;  count_reg <= 16'h0000;
      hdr_reg <= 16'h0000;  haveHdr_reg <= 1'b0;  msgDone_reg <= 1'b0;
      cmdData_reg <= 16'h0000;  cmdLast_reg <= 1'b0;
      cmdValid_reg <= 1'b0;  irq_reg <= 1'b0;  irqRsp_reg <= 1'b0;
      credit_reg <= drmp_pkg::CREDIT_RST;
    end else begin
      state_reg <= state_next;  memReq_reg <= memReq_next;
      memWe_reg <= memWe_next;  memAddr_reg <= memAddr_next;
      memWdata_reg <= memWdata_next;  isRsp_reg <= isRsp_next;
      cmdIdx_reg <= cmdIdx_next;  rspIdx_reg <= rspIdx_next;
      cmdPend_reg <= cmdPend_next;  descHi_reg <= descHi_next;
      envAddr_reg <= envAddr_next;  prevOwn_reg <= prevOwn_next;
      bufLen_reg <= bufLen_next;  count_reg <= count_next;
      hdr_reg <= hdr_next;  haveHdr_reg <= haveHdr_next;
      msgDone_reg <= msgDone_next;  cmdData_reg <= cmdData_next;
      cmdLast_reg <= cmdLast_next;  cmdValid_reg <= cmdValid_next;
      irq_reg <= irq_next;  irqRsp_reg <= irqRsp_next;
      credit_reg <= credit_next;
    end
  end

  assign memReq = memReq_reg;      assign memWe = memWe_reg;
  assign memAddr = memAddr_reg;    assign memWdata = memWdata_reg;
  assign cmdData = cmdData_reg;    assign cmdLast = cmdLast_reg;
  assign cmdValid = cmdValid_reg;  assign hostIrq = irq_reg;
  assign irqRsp = irqRsp_reg;      assign creditTotal = credit_reg;

  // Checks on the sequencer and bus
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_desc_return: assert property (memReq && state_reg == drmp_pkg::S_DWR
    |-> memWe && !memWdata[15] && memWdata[14])
    else $error("returned descriptor not host owned with flag");
  a_env_align: assert property (memReq && state_reg == drmp_pkg::S_LEN
    |-> memAddr[1:0] == 2'b00 || memAddr[0] == 1'b0)
    else $error("envelope address odd");
  a_irq_cause: assert property (hostIrq |-> $past(state_reg)
    == drmp_pkg::S_DWR && $past(descHi_reg[14]) && $past(prevOwn_reg)
    && $past(xitionIntEn))
    else $error("interrupt without cause");
  a_ring_wrap: assert property (cmdRingLen != 8'h00 && $stable(cmdRingLen)
    && cmdIdx_reg < cmdRingLen |=> cmdIdx_reg < cmdRingLen)
    else $error("command index past ring end");
  a_len_write: assert property (memReq && state_reg == drmp_pkg::S_LENW
    |-> memWdata == count_reg && memWe)
    else $error("length field not actual length");
  a_frag_bound: assert property (memReq && memWe && isRsp_reg &&
    state_reg == drmp_pkg::S_TXT |-> nextCount <= {1'b0, bufLen_reg})
    else $error("response overruns slot");
  a_req_hold: assert property (memReq && !memAck
    |=> memReq && $stable(memWe) && $stable(memAddr)
    && $stable(memWdata))
    else $error("bus request dropped early");
  a_cmd_hold: assert property (cmdValid && !cmdReady
    |=> cmdValid && $stable(cmdData) && $stable(cmdLast))
    else $error("command word changed while stalled");
  c_irq: cover property (hostIrq && irqRsp);
  c_frag: cover property (state_reg == drmp_pkg::S_LENW && !msgDone_reg);
  c_cmd_last: cover property (cmdValid && cmdReady && cmdLast);
endmodule : drmp_port

// ===== dv/drmp_host_mem.sv
// Host memory model answering the port's word accesses
`timescale 1ns/1ps
module drmp_host_mem (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Word access from the port
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [15:0] memWdata,
  output logic [15:0]      memRdata,
  output logic             memAck
);
  logic [15:0] mem [0:1023]; // Word store, byte address bits 10:1
  int          stall = 0;    // Cycles withheld before each ack
  int          waitCnt = 0;  // Cycles waited on this access
  // Empty memory, bus quiet
  initial begin
    memAck   = 1'b0;
    memRdata = 16'h0000;
    foreach (mem[i]) mem[i] = 16'h0000;
  end
  // One access at a time; read bus keeps toggling when not answering
  always @(posedge clk) begin
    memAck   <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck && !rst) begin
      if (waitCnt >= stall) begin
        memAck  <= 1'b1;
        waitCnt <= 0;
        // Host stores every write, controller-owned words included
        if (memWe) mem[memAddr[10:1]] <= memWdata;
        else memRdata <= mem[memAddr[10:1]];
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end
  end
endmodule : drmp_host_mem

// ===== dv/test_descriptor_ring_message_port.sv
// Self-checking bench for the descriptor ring message port
`timescale 1ns/1ps
module test_descriptor_ring_message_port;
  // One response message and what it should leave behind
  typedef struct {
    logic [15:0] hdr;  // Header word pushed first
    logic [15:0] txt;  // Single text word
    logic        flag; // Interrupt request in the slot
    logic        slot; // Slot expected to take it
    logic        kept; // Message lands in a slot
    logic [15:0] cred; // Credit total afterwards
  } drmp_row_t;
  // Design inputs, all set at time zero
  logic clk = 1'b0, rst = 1'b1, runEn = 1'b0, pollReq = 1'b0;
  logic rspLast = 1'b0, rspValid = 1'b0, cmdReady = 1'b0;
  logic [15:0] rspData = 16'h0000;
  // Design and host memory outputs
  logic memReq, memWe, memAck, rspReady, cmdLast, cmdValid, hostIrq;
  logic irqRsp;
  logic [31:0] memAddr;
  logic [15:0] memWdata, memRdata, cmdData, creditTotal;
  // Bench state
  int error_cnt = 0, checks = 0, cyc = 0, irqCnt = 0, n;
  logic irqSide;
  logic [16:0] cmdQ [$];    // Accepted command words with last flag
  logic [31:0] e;
  logic [15:0] x;
  drmp_row_t rows [4] = '{
    '{{8'h5a, drmp_pkg::maintenance_packet, 4'h1}, 16'hc001, 1, 0, 1, 1},
    '{{8'h5a, drmp_pkg::credit_notice, 4'h2}, 16'hc002, 1, 1, 0, 3},
    '{{8'h5a, drmp_pkg::datagram_packet, 4'h1}, 16'hc003, 0, 1, 1, 4},
    '{{8'h5a, drmp_pkg::sequential_packet, 4'h3}, 16'hc004, 1, 0, 1, 7}};
  // Device under test and host memory
  drmp_port i_drmp_port (.clk(clk), .rst(rst), .runEn(runEn),
    .commBase(32'h0000_0100), .cmdRingLen(8'h02), .rspRingLen(8'h02),
    .xitionIntEn(1'b1), .pollReq(pollReq), .memReq(memReq), .memWe(memWe),
    .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
    .memAck(memAck), .rspData(rspData), .rspLast(rspLast),
    .rspValid(rspValid), .rspReady(rspReady), .cmdData(cmdData),
    .cmdLast(cmdLast), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .hostIrq(hostIrq), .irqRsp(irqRsp), .creditTotal(creditTotal));
  drmp_host_mem i_drmp_host_mem (.clk(clk), .rst(rst), .memReq(memReq),
    .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
    .memRdata(memRdata), .memAck(memAck));
  // Clock, 8 ns period
  initial forever #4 clk = ~clk;
  // Consumer stalls every other cycle
  always @(negedge clk) cmdReady <= ~cmdReady;
  // Watch interrupts and command stream, cut hangs short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (hostIrq === 1'b1) irqCnt <= irqCnt + 1;
    if (hostIrq === 1'b1) irqSide <= irqRsp;
    if (cmdValid === 1'b1 && cmdReady === 1'b1)
      cmdQ.push_back({cmdLast, cmdData});
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // Compare one value
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : check
  // Memory word access by byte address
  function automatic logic [15:0] rd(logic [31:0] a);
    return i_drmp_host_mem.mem[a[10:1]];
  endfunction : rd
  task automatic wr(logic [31:0] a, logic [15:0] d);
    i_drmp_host_mem.mem[a[10:1]] = d;
  endtask : wr
  // Offer a response slot: pointer, owner/flag, buffer size
  task automatic prep(logic s, logic f, logic [15:0] size);
    wr(32'h104 + 4 * s, s ? 16'h0340 : 16'h0300);
    wr(32'h106 + 4 * s, {1'b1, f, 14'h0});
    wr((s ? 32'h340 : 32'h300) - 4, size);
  endtask : prep
  // Push one response word, held until taken
  task automatic push(logic [15:0] d, logic l);
    @(negedge clk);
    rspData  = d;
    rspLast  = l;
    rspValid = 1'b1;
    @(posedge clk);
    while (rspReady !== 1'b1) @(posedge clk);
  endtask : push
  // Wait, bounded, until a descriptor returns to the host
  task automatic wait_own(logic [31:0] a);
    int k;
    k = 0;
    while (i_drmp_host_mem.mem[a[10:1]][15] !== 1'b0 && k < 800) begin
      @(posedge clk);
      k++;
    end
    repeat (4) @(posedge clk);
  endtask : wait_own
  // Outputs quiet under reset
  task automatic chk_reset();
    check("memReq", 0, memReq);
    check("cmdValid", 0, cmdValid);
    check("hostIrq", 0, hostIrq);
    check("creditTotal", 0, creditTotal);
    check("rspReady", 0, rspReady);
  endtask : chk_reset
  // Verdict
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  // Main sequence
  initial begin
    repeat (10) @(negedge clk);
    chk_reset();
    rst   = 1'b0;
    runEn = 1'b1;
    repeat (3) @(negedge clk);
    check("rspReady", 1, rspReady);
    $display("test reset done");
    // Each response type pushed in turn; all but credit notice land in the ring
    foreach (rows[r]) begin
      prep(rows[r].slot, rows[r].flag, 16'h0008);
      prep(~rows[r].slot, 1'b1, 16'h0008);
      n = irqCnt;
      push(rows[r].hdr, 1'b0);
      push(rows[r].txt, 1'b1);
      @(negedge clk) rspValid = 1'b0;
      e = rows[r].slot ? 32'h340 : 32'h300;
      x = rows[r].kept ? 16'h4000 : {1'b1, rows[r].flag, 14'h0};
      if (rows[r].kept) wait_own(32'h106 + 4 * rows[r].slot);
      else repeat (80) @(posedge clk);
      check("creditTotal", rows[r].cred, creditTotal);
      check("slotHi", x, rd(32'h106 + 4 * rows[r].slot));
      check("irq", rows[r].kept & rows[r].flag, irqCnt - n);
      if (rows[r].kept) begin
        check("hdr", rows[r].hdr, rd(e - 2));
        check("txt", rows[r].txt, rd(e));
        check("len", 16'h0002, rd(e - 4));
      end
      if (rows[r].kept & rows[r].flag) check("irqRsp", 1, irqSide);
      $display("test row %0d done", r);
    end
    // Long response split over two slots, second not a transition
    prep(1'b1, 1'b1, 16'h0004);
    prep(1'b0, 1'b1, 16'h0008);
    n = irqCnt;
    push(16'h5a31, 1'b0);
    push(16'h1111, 1'b0);
    push(16'h2222, 1'b0);
    push(16'h3333, 1'b1);
    @(negedge clk) rspValid = 1'b0;
    wait_own(32'h106);
    check("fragLen1", 16'h0004, rd(32'h33c));
    check("fragTxt1", 16'h2222, rd(32'h342));
    check("fragLen0", 16'h0002, rd(32'h2fc));
    check("fragHdr0", 16'h5a31, rd(32'h2fe));
    check("fragTxt0", 16'h3333, rd(32'h300));
    check("fragHi0", 16'h4000, rd(32'h106));
    check("fragIrq", 1, irqCnt - n);
    $display("test fragment done");
    // Command from an odd pointer over a slow memory
    i_drmp_host_mem.stall = 2;
    wr(32'h10c, 16'h0401);
    wr(32'h10e, 16'hc000);
    wr(32'h112, 16'h0000);
    wr(32'h3fc, 16'h0004);
    wr(32'h3fe, 16'h7720);
    wr(32'h400, 16'haaaa);
    wr(32'h402, 16'hbbbb);
    n = irqCnt;
    @(negedge clk) pollReq = 1'b1;
    @(negedge clk) pollReq = 1'b0;
    wait_own(32'h10e);
    check("cmdHi", 16'h4000, rd(32'h10e));
    check("cmdCnt", 3, cmdQ.size());
    check("cmd0", 17'h07720, cmdQ[0]);
    check("cmd1", 17'h0aaaa, cmdQ[1]);
    check("cmd2", 17'h1bbbb, cmdQ[2]);
    check("cmdIrq", 0, irqCnt - n);
    $display("test command done");
    // Reset again in mid-run
    @(negedge clk) rst = 1'b1;
    repeat (2) @(negedge clk);
    chk_reset();
    // Release again: buffer opens, bus stays quiet
    @(negedge clk) rst = 1'b0;
    repeat (2) @(negedge clk);
    check("rspReady", 1, rspReady);
    check("memReq", 0, memReq);
    $display("test second reset done");
    close_out();
  end
endmodule : test_descriptor_ring_message_port
